// ===== src/atcc_pkg.sv
// package: register map, field layout and timing constants of the converter control
package atcc_pkg;
  // register byte addresses on the apb bus (one word each)
  localparam logic [11:0] TRIG_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] CTRL_STAT_ADDR   = 12'h004;
  localparam logic [11:0] IRQ_STAT_ADDR    = 12'h008;
  localparam logic [11:0] IRQ_MASK_ADDR    = 12'h00c;
  localparam logic [11:0] RESULT_ADDR      = 12'h010;
  // trigger control layout
  localparam int          TRIG_EN_BIT      = 7;
  localparam logic [7:0]  TRIG_CTRL_RESET  = 8'h7f;  // unused bits read one
  // control/status layout
  localparam int          END_FLAG_BIT     = 7;
  localparam int          IRQ_EN_BIT       = 6;
  localparam int          START_BIT        = 5;
  localparam int          SCAN_BIT         = 4;
  localparam int          CLK_SEL_BIT      = 3;
  localparam int          INPUT_SEL_MSB    = 2;
  localparam logic [7:0]  CTRL_STAT_RESET  = 8'h00;
  // interrupt status/mask layout
  localparam int          EV_DONE_BIT      = 0;  // conversion ended
  localparam int          EV_TRIG_BIT      = 1;  // external trigger accepted
  localparam int          EV_WIDTH         = 2;
  // conversion times in states
  localparam int          SLOW_STATES      = 266;
  localparam int          FAST_STATES      = 134;
  localparam int          CNT_W            = 9;
  localparam logic [CNT_W-1:0] SLOW_CYCLES = CNT_W'(SLOW_STATES);
  localparam logic [CNT_W-1:0] FAST_CYCLES = CNT_W'(FAST_STATES);
  localparam logic [31:0] APB_ERR_DATA     = 32'h0000_0000;
  localparam logic [2:0]  IN_COUNT         = 3'h4;   // inputs per scan group
  // converter sequencer states
  typedef enum logic [2:0] {
    ATCC_IDLE = 3'b001,
    ATCC_CONV = 3'b010,
    ATCC_DONE = 3'b100
  } atcc_state_e;
endpackage : atcc_pkg

// ===== src/atcc_ctl_if.sv
// interface: register fields and events between the apb slave and the sequencer
interface atcc_ctl_if;
  logic       trig_enable;    // external trigger armed
  logic       irq_enable;     // conversion interrupt enable
  logic       scan_mode;      // scan over a group of inputs
  logic       clk_select;     // one = fast conversion
  logic [2:0] input_select;   // channel field
  logic       sw_start;       // one-cycle start from software write
  logic       busy;           // conversion in progress
  logic       done_pulse;     // one-cycle end of whole conversion
  logic       trig_pulse;     // one-cycle accepted external trigger
  logic [2:0] cur_input;      // input now being converted
  modport regs (output trig_enable, irq_enable, scan_mode, clk_select, input_select,
                output sw_start, input busy, done_pulse, trig_pulse, cur_input);
  modport seq  (input trig_enable, irq_enable, scan_mode, clk_select, input_select,
                input sw_start, output busy, done_pulse, trig_pulse, cur_input);
endinterface : atcc_ctl_if

// ===== src/atcc_seq.sv
// module: conversion sequencer with external trigger edge detection
module atcc_seq (
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  wire logic  trig_pin,
  atcc_ctl_if.seq    ctl
);
  typedef struct packed {
    atcc_pkg::atcc_state_e            state;
    logic [atcc_pkg::CNT_W-1:0]       cnt;     // states left in this input
    logic [2:0]                       cur;     // current input
    logic [2:0]                       last;    // last input of the group
    logic                             pin_d;   // previous trigger pin level
    logic                             done;    // end pulse
    logic                             trig;    // trigger pulse
  } atcc_seq_s;
  atcc_seq_s s_reg, s_next;

  // conversion length for the selected clock
  function automatic logic [atcc_pkg::CNT_W-1:0] conv_len(input logic fast);
    conv_len = fast ? atcc_pkg::FAST_CYCLES : atcc_pkg::SLOW_CYCLES;
  endfunction

  logic fall;
  // falling edge only counts while armed
  assign fall = ctl.trig_enable && s_reg.pin_d && !trig_pin;

  // next-state logic
  always_comb begin
    s_next       = s_reg;
    s_next.pin_d = trig_pin;
    s_next.done  = 1'b0;
    s_next.trig  = 1'b0;
    unique case (s_reg.state)
      atcc_pkg::ATCC_IDLE: begin
        if (ctl.sw_start || fall) begin
          s_next.state = atcc_pkg::ATCC_CONV;
          s_next.trig  = fall && !ctl.sw_start;
          // scan starts at group base, single uses the field directly
          s_next.cur   = ctl.scan_mode ? {ctl.input_select[2], 2'b00}
                                       : ctl.input_select;
          s_next.last  = ctl.input_select;
          // count minus two, the done state supplies the last state
          s_next.cnt   = conv_len(ctl.clk_select) - atcc_pkg::CNT_W'(2);
        end
      end
      atcc_pkg::ATCC_CONV: begin
        if (s_reg.cnt != '0) begin
          s_next.cnt = s_reg.cnt - atcc_pkg::CNT_W'(1);
        end else if (ctl.scan_mode && s_reg.cur != s_reg.last) begin
          // next input of the group restarts the timer
          s_next.cur = s_reg.cur + 3'h1;
          s_next.cnt = conv_len(ctl.clk_select) - atcc_pkg::CNT_W'(1);
        end else begin
          s_next.state = atcc_pkg::ATCC_DONE;
        end
      end
      atcc_pkg::ATCC_DONE: begin
        s_next.state = atcc_pkg::ATCC_IDLE;
        s_next.done  = 1'b1;
      end
      default: s_next.state = atcc_pkg::ATCC_IDLE;  // illegal code recovers
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{state: atcc_pkg::ATCC_IDLE, cnt: '0, cur: 3'h0, last: 3'h0,
                 pin_d: 1'b1, done: 1'b0, trig: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign ctl.busy       = (s_reg.state != atcc_pkg::ATCC_IDLE);
  assign ctl.done_pulse = s_reg.done;
  assign ctl.trig_pulse = s_reg.trig;
  assign ctl.cur_input  = s_reg.cur;

  // cycles in one single conversion
  logic [atcc_pkg::CNT_W:0] run_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) run_cnt <= '0;
    else if (s_reg.state == atcc_pkg::ATCC_IDLE) run_cnt <= '0;
    else run_cnt <= run_cnt + (atcc_pkg::CNT_W+1)'(1);
  end

  a_trig_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (!ctl.trig_enable && !ctl.sw_start && s_reg.state == atcc_pkg::ATCC_IDLE)
      |=> s_reg.state == atcc_pkg::ATCC_IDLE) else $error("trigger not ignored");
  a_trig_starts: assert property (@(posedge clk) disable iff (!rst_b)
    (fall && s_reg.state == atcc_pkg::ATCC_IDLE)
      |=> s_reg.state == atcc_pkg::ATCC_CONV) else $error("trigger edge missed");
  a_slow_time: assert property (@(posedge clk) disable iff (!rst_b)
    (s_reg.done && !ctl.scan_mode && !ctl.clk_select)
      |-> run_cnt <= (atcc_pkg::CNT_W+1)'(atcc_pkg::SLOW_STATES))
    else $error("slow conversion too long");
  a_fast_time: assert property (@(posedge clk) disable iff (!rst_b)
    (s_reg.done && !ctl.scan_mode && ctl.clk_select)
      |-> run_cnt <= (atcc_pkg::CNT_W+1)'(atcc_pkg::FAST_STATES))
    else $error("fast conversion too long");
  a_single_input: assert property (@(posedge clk) disable iff (!rst_b)
    (s_reg.state == atcc_pkg::ATCC_IDLE && ctl.sw_start && !ctl.scan_mode)
      |=> s_reg.cur == $past(ctl.input_select)) else $error("wrong single input");
  // counted from entry into convert; the start pulse sits one stage before it
  a_fast_bound: assert property (@(posedge clk) disable iff (!rst_b)
    (s_reg.state == atcc_pkg::ATCC_IDLE && ctl.sw_start && ctl.clk_select
     && !ctl.scan_mode) |=> ##[1:134] s_reg.done) else $error("fast end late");
  c_fast_done: cover property (@(posedge clk) s_reg.done && ctl.clk_select);
  c_ext_start: cover property (@(posedge clk) s_reg.trig);
  c_scan_run:  cover property (@(posedge clk) s_reg.done && ctl.scan_mode);
endmodule : atcc_seq

// ===== src/atcc_top.sv
// module: converter trigger and clock control with apb register slave
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module atcc_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_CONVERT_TRIGGER_PIN,
  output logic             CONV_IRQ,
  output logic             IRQ
);
  atcc_ctl_if ctl ();

  typedef struct packed {
    logic                          trig_en;   // trigger enable field
    logic [7:0]                    ctrl;      // control/status byte
    logic                          end_seen;  // flag was read as one
    logic [atcc_pkg::EV_WIDTH-1:0] ev_stat;   // sticky events
    logic [atcc_pkg::EV_WIDTH-1:0] ev_mask;   // event mask
    logic                          start;     // start pulse to sequencer
    logic [31:0]                   rdata;     // apb read data
    logic                          ready;     // apb ready
    logic                          err;       // apb error
    logic                          conv_irq;  // conversion interrupt line
    logic                          irq;       // masked event interrupt
  } atcc_top_s;
  atcc_top_s r_reg, r_next;

  logic acc, wr, rd, hit;
  // access phase, answered in one cycle with ready
  assign acc = PSEL && PENABLE && !r_reg.ready;
  assign wr  = acc && PWRITE && PSTRB[0];
  assign rd  = acc && !PWRITE;
  assign hit = (PADDR == atcc_pkg::TRIG_CTRL_ADDR) || (PADDR == atcc_pkg::CTRL_STAT_ADDR)
            || (PADDR == atcc_pkg::IRQ_STAT_ADDR)  || (PADDR == atcc_pkg::IRQ_MASK_ADDR)
            || (PADDR == atcc_pkg::RESULT_ADDR);

  // trigger control byte as seen by software
  function automatic logic [7:0] trig_byte(input logic en);
    trig_byte = atcc_pkg::TRIG_CTRL_RESET;
    trig_byte[atcc_pkg::TRIG_EN_BIT] = en;
  endfunction

  // register and bus logic
  always_comb begin
    logic [7:0] wb;
    logic [7:0] c;
    wb = PWDATA[7:0];
    c  = r_reg.ctrl;
    r_next       = r_reg;
    r_next.ready = acc;
    r_next.err   = acc && !hit;
    r_next.rdata = atcc_pkg::APB_ERR_DATA;
    r_next.start = 1'b0;
    if (wr && PADDR == atcc_pkg::TRIG_CTRL_ADDR) begin
      r_next.trig_en = wb[atcc_pkg::TRIG_EN_BIT];
    end
    if (wr && PADDR == atcc_pkg::CTRL_STAT_ADDR) begin
      // flag accepts only a zero, and only after it was read as one
      c[atcc_pkg::IRQ_EN_BIT:0] = wb[atcc_pkg::IRQ_EN_BIT:0];
      if (!wb[atcc_pkg::END_FLAG_BIT] && r_reg.end_seen) begin
        c[atcc_pkg::END_FLAG_BIT] = 1'b0;
        r_next.end_seen = 1'b0;
      end
      // start bit can be cleared while busy from this simple path
      if (wb[atcc_pkg::START_BIT] && !r_reg.ctrl[atcc_pkg::START_BIT]) begin
        r_next.start = 1'b1;
      end
      // scan, clock select and input field changes are frozen during a conversion to keep it coherent
      if (ctl.busy) begin
        c[atcc_pkg::SCAN_BIT:0] = r_reg.ctrl[atcc_pkg::SCAN_BIT:0];
      end
    end
    if (ctl.trig_pulse) begin
      c[atcc_pkg::START_BIT] = 1'b1;  // external start shows as busy
    end
    if (ctl.done_pulse) begin
      c[atcc_pkg::END_FLAG_BIT] = 1'b1;  // set wins over clear
      c[atcc_pkg::START_BIT]    = 1'b0;
    end
    r_next.ctrl = c;
    if (rd && PADDR == atcc_pkg::CTRL_STAT_ADDR && r_reg.ctrl[atcc_pkg::END_FLAG_BIT]) begin
      r_next.end_seen = 1'b1;
    end
    if (wr && PADDR == atcc_pkg::IRQ_MASK_ADDR) begin
      r_next.ev_mask = wb[atcc_pkg::EV_WIDTH-1:0];
    end
    // read data
    if (rd) begin
      unique case (PADDR)
        atcc_pkg::TRIG_CTRL_ADDR: r_next.rdata = {24'h0, trig_byte(r_reg.trig_en)};
        atcc_pkg::CTRL_STAT_ADDR: r_next.rdata = {24'h0, r_reg.ctrl};
        atcc_pkg::IRQ_STAT_ADDR:  r_next.rdata = {30'h0, r_reg.ev_stat};
        atcc_pkg::IRQ_MASK_ADDR:  r_next.rdata = {30'h0, r_reg.ev_mask};
        atcc_pkg::RESULT_ADDR:    r_next.rdata = {29'h0, ctl.cur_input};
        default:                  r_next.rdata = atcc_pkg::APB_ERR_DATA;
      endcase
    end
    // sticky events cleared by reading, a new event wins
    if (rd && PADDR == atcc_pkg::IRQ_STAT_ADDR) begin
      r_next.ev_stat = '0;
    end
    if (ctl.done_pulse) r_next.ev_stat[atcc_pkg::EV_DONE_BIT] = 1'b1;
    if (ctl.trig_pulse) r_next.ev_stat[atcc_pkg::EV_TRIG_BIT] = 1'b1;
    r_next.irq      = |(r_next.ev_stat & r_next.ev_mask);
    r_next.conv_irq = c[atcc_pkg::END_FLAG_BIT] && c[atcc_pkg::IRQ_EN_BIT];
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r_reg <= '{trig_en: 1'b0, ctrl: atcc_pkg::CTRL_STAT_RESET, end_seen: 1'b0,
                 ev_stat: '0, ev_mask: '0, start: 1'b0, rdata: '0, ready: 1'b0,
                 err: 1'b0, conv_irq: 1'b0, irq: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // fields handed to the sequencer
  assign ctl.trig_enable  = r_reg.trig_en;
  assign ctl.irq_enable   = r_reg.ctrl[atcc_pkg::IRQ_EN_BIT];
  assign ctl.scan_mode    = r_reg.ctrl[atcc_pkg::SCAN_BIT];
  assign ctl.clk_select   = r_reg.ctrl[atcc_pkg::CLK_SEL_BIT];
  assign ctl.input_select = r_reg.ctrl[atcc_pkg::INPUT_SEL_MSB:0];
  assign ctl.sw_start     = r_reg.start;

  atcc_seq u_seq (
    .clk      (CORE_CLK),
    .rst_b    (RST_B),
    .trig_pin (EXT_CONVERT_TRIGGER_PIN),
    .ctl      (ctl)
  );

  assign PRDATA   = r_reg.rdata;
  assign PREADY   = r_reg.ready;
  assign PSLVERR  = r_reg.err;
  assign CONV_IRQ = r_reg.conv_irq;
  assign IRQ      = r_reg.irq;

  a_flag_sets: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    ctl.done_pulse |=> r_reg.ctrl[atcc_pkg::END_FLAG_BIT]) else $error("end flag not set");
  a_irq_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (ctl.done_pulse && r_reg.ctrl[atcc_pkg::IRQ_EN_BIT]) |=> CONV_IRQ)
    else $error("irq missing");
  a_no_blind_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (r_reg.ctrl[atcc_pkg::END_FLAG_BIT] && !r_reg.end_seen)
      |=> r_reg.ctrl[atcc_pkg::END_FLAG_BIT])
    else $error("flag cleared unread");
  a_apb_ready: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (PSEL && PENABLE && !PREADY) |=> PREADY) else $error("apb answer late");
  c_flag_clear: cover property (@(posedge CORE_CLK) $fell(r_reg.ctrl[atcc_pkg::END_FLAG_BIT]));
endmodule : atcc_top

// ===== test/atcc_trig_src.sv
// model: external trigger source that drives the conversion start pin
module atcc_trig_src (
  input  wire logic clk,      // bench clock, pin changes just after its edges
  output logic      trig_pin  // trigger pin seen by the converter
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle level high, so only a commanded pulse can make a falling edge
  initial trig_pin = 1'b1;

  // one falling edge; held low several edges so a two-edge detector sees it
  task automatic fall(input int low_cycles);
    @(posedge clk);
    trig_pin <= 1'b0;
    repeat (low_cycles) @(posedge clk);
    trig_pin <= 1'b1;
  endtask
endmodule // atcc_trig_src

// ===== test/tb_adc_trigger_and_clock_control.sv
// testbench: converter trigger and clock control driven over apb
module tb_adc_trigger_and_clock_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;          // 250 mhz core clock
  logic        rst_b;        // async reset, active low
  logic        psel;         // apb select
  logic        penable;      // apb access phase
  logic        pwrite;       // apb direction
  logic [11:0] paddr;        // apb byte address
  logic [31:0] pwdata;       // apb write data
  logic [31:0] prdata;       // apb read data
  logic        pready;       // apb answer
  logic        pslverr;      // apb unmapped flag
  logic        trig_pin;     // from the trigger model
  logic        conv_irq;     // end flag and irq enable
  logic        irq;          // masked event status
  int          err_total;    // mismatches
  int          n_compared;   // comparisons made
  int          cyc;          // timeout counter

  // clock: 4 ns period
  always #2 clk = ~clk;

  atcc_top dut_u (
    .CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_CONVERT_TRIGGER_PIN(trig_pin), .CONV_IRQ(conv_irq),
    .IRQ(irq)
  );

  atcc_trig_src trig_u (.clk(clk), .trig_pin(trig_pin));

  // single place for a comparison and its report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // bounded wait: a missing answer is a mismatch, not a hang
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask

  // cycles until the masked interrupt shows, at most 1000
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // software start; irq shows two register stages after the conversion ends
  task automatic conv(input logic [7:0] ctl, input int states);
    int n;
    wr(atcc_pkg::CTRL_STAT_ADDR, {24'h0, ctl});
    wait_irq(n);
    chk(32'(n >= states - 2 && n <= states + 2), 32'h1);
  endtask

  // reset values, unmapped address refused
  task automatic s_reset();
    logic [31:0] rd;
    logic        err;
    rd_chk(atcc_pkg::TRIG_CTRL_ADDR, 32'h7f);
    rd_chk(atcc_pkg::CTRL_STAT_ADDR, 32'h00);
    rd_chk(atcc_pkg::IRQ_MASK_ADDR, 32'h0);
    apb(1'b0, 12'h020, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask

  // slow single conversion on input 3, end flag handling
  task automatic s_slow();
    wr(atcc_pkg::IRQ_MASK_ADDR, 32'h3);
    conv(8'h63, atcc_pkg::SLOW_STATES);
    chk(32'(conv_irq), 32'h1);
    // flag zero written before any read of one: must not clear
    wr(atcc_pkg::CTRL_STAT_ADDR, 32'h43);
    rd_chk(atcc_pkg::CTRL_STAT_ADDR, 32'hc3);
    wr(atcc_pkg::CTRL_STAT_ADDR, 32'h43);
    rd_chk(atcc_pkg::CTRL_STAT_ADDR, 32'h43);
    chk(32'(conv_irq), 32'h0);
    rd_chk(atcc_pkg::RESULT_ADDR, 32'h3);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h1);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h0);
  endtask

  // fast single on input 5 with irq enable off, then scan of group 4..6
  task automatic s_fast_scan();
    conv(8'h2d, atcc_pkg::FAST_STATES);
    chk(32'(conv_irq), 32'h0);
    rd_chk(atcc_pkg::RESULT_ADDR, 32'h5);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h1);
    conv(8'h3e, 3 * atcc_pkg::FAST_STATES);
    rd_chk(atcc_pkg::RESULT_ADDR, 32'h6);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h1);
  endtask

  // trigger pin disarmed, then armed
  task automatic s_trig();
    int n;
    trig_u.fall(4);
    repeat (300) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h0);
    wr(atcc_pkg::TRIG_CTRL_ADDR, 32'h80);
    rd_chk(atcc_pkg::TRIG_CTRL_ADDR, 32'hff);
    trig_u.fall(4);
    repeat (4) @(posedge clk);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h2);
    wait_irq(n);
    chk(32'(n < 1000), 32'h1);
    rd_chk(atcc_pkg::IRQ_STAT_ADDR, 32'h1);
  endtask

  // hang guard, far above the roughly 1600 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("[FAIL] %0t: run timed out", $time);
      end_of_test();
    end
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    s_reset();
    s_slow();
    s_fast_scan();
    s_trig();
    end_of_test();
  end
endmodule // tb_adc_trigger_and_clock_control
